// file: verif/msoc_host.sv
// Host processor model: AXI4-Lite master for register service
`timescale 1ns/1ps

module msoc_host
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // Raised when an answer never comes
  output logic stuck
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, stuck} = '0;
  end

  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    int n;
    logic a_ok;
    logic w_ok;
    logic b_ok;
    n = 0;
    a_ok = 0;
    w_ok = 0;
    b_ok = 0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (!a_ok && awready)
      begin
        awvalid <= 1'b0;
        a_ok = 1;
      end
      if (!w_ok && wready)
      begin
        wvalid <= 1'b0;
        w_ok = 1;
      end
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        b_ok = 1;
      end
    end
    if (!b_ok)
      stuck <= 1'b1;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    int n;
    logic a_ok;
    logic r_ok;
    n = 0;
    a_ok = 0;
    r_ok = 0;
    d = '1;
    resp = 2'h3;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (!a_ok && arready)
      begin
        arvalid <= 1'b0;
        a_ok = 1;
      end
      if (rvalid)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        r_ok = 1;
      end
    end
    if (!r_ok)
      stuck <= 1'b1;
  endtask
endmodule

// file: verif/tb.sv
// Self-checking testbench of the motion, sleep and offset controller
`timescale 1ns/1ps
`include "msoc_map.svh"

module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic smp_valid = 0;
  logic signed [12:0] smp_x = 0;
  logic signed [12:0] smp_y = 0;
  logic signed [12:0] smp_z = 0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, asleep, stuck;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] d16;
  logic signed [12:0] raw [3] = '{13'sd10, -13'sd13, 13'sd9};
  logic [7:0] ofs [3] = '{8'hFD, 8'h03, 8'hFE};
  int err_total = 0;
  int comparisons = 0;

  always #5 aclk = ~aclk;

  msoc_ctrl uut (.aclk, .aresetn, .smp_valid, .smp_x, .smp_y, .smp_z,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq, .asleep);

  msoc_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .stuck);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdc(input string what, input logic [5:0] idx,
                     input logic [7:0] mask, input logic [7:0] exp);
    host.rd(idx, v, rs);
    chk(what, v & {24'h000000, mask}, {24'h000000, exp});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    host.wr(idx, d, rs);
  endtask

  task automatic rd16(input logic [5:0] idx);
    host.rd(idx, v, rs);
    d16[7:0] = v[7:0];
    host.rd(idx + 6'h01, v, rs);
    d16[15:8] = v[7:0];
  endtask

  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic smp(input logic signed [12:0] x, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      smp_valid <= 1'b1;
      smp_x <= x;
      smp_y <= -x;
      smp_z <= x;
      @(posedge aclk);
      smp_valid <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask

  function automatic logic [15:0] fix(input logic signed [12:0] r,
    input logic signed [7:0] o, input int sh);
    logic signed [15:0] s;
    logic signed [15:0] t;
    s = r;
    t = o;
    case (sh)
      0: t = t <<< 2;
      1: t = t <<< 1;
      3: t = t >>> 1;
      default: t = t;
    endcase
    return (s >>> sh) + t;
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge stuck)
  begin
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst();
    for (int i = 0; i < 3; i++)
      rdc("ofs reset", `MSOC_IDX_OFS_X + 6'(i), 8'hFF, 8'h00);
    rdc("bw_rate reset", `MSOC_IDX_BW_RATE, 8'hFF, `MSOC_RST_BW_RATE);
    host.rd(6'h3F, v, rs);
    chk("unmapped rdata", v, 32'h00000000);
    chk("unmapped rresp", 32'(rs), 32'(`MSOC_RESP_SLVERR));
    host.wr(`MSOC_IDX_STATUS, 8'hFF, rs);
    chk("ro bresp", 32'(rs), 32'(`MSOC_RESP_SLVERR));
    for (int i = 0; i < 3; i++)
      wr(`MSOC_IDX_OFS_X + 6'(i), ofs[i]);
    for (int i = 0; i < 3; i++)
      rdc("ofs back", `MSOC_IDX_OFS_X + 6'(i), 8'hFF, ofs[i]);
    wr(`MSOC_IDX_PWR, 8'h08);
    wr(`MSOC_IDX_BW_RATE, 8'h0F);
    wr(`MSOC_IDX_FMT, 8'h08);
    for (int k = 0; k < 10; k++)
    begin
      @(posedge aclk);
      smp_valid <= 1'b1;
      {smp_x, smp_y, smp_z} <= {raw[0], raw[1], raw[2]};
      @(posedge aclk);
      smp_valid <= 1'b0;
    end
    for (int a = 0; a < 3; a++)
    begin
      rd16(`MSOC_IDX_DATA_FIRST + 6'(2 * a));
      chk("full res data", 32'(d16), 32'(fix(raw[a], ofs[a], 0)));
    end
    for (int r = 0; r < 4; r++)
    begin
      wr(`MSOC_IDX_FMT, 8'(r));
      smp(13'sd40, 1);
      rd16(`MSOC_IDX_DATA_FIRST);
      chk("range data", 32'(d16), 32'(fix(13'sd40, ofs[0], r)));
    end
    rst();
    rdc("ofs after reset", `MSOC_IDX_OFS_X, 8'hFF, 8'h00);
    $display("test offsets done");

    wr(`MSOC_IDX_PWR, 8'h08);
    wr(`MSOC_IDX_BW_RATE, 8'h0E);
    wr(`MSOC_IDX_INT_EN, 8'h80);
    smp(13'sd0, 1);
    chk("irq after one sample", 32'(irq), 32'h0);
    smp(13'sd0, 1);
    chk("irq data ready", 32'(irq), 32'h1);
    rdc("int_src ready", `MSOC_IDX_INT_SRC, 8'h80, 8'h80);
    repeat (2) @(posedge aclk);
    chk("irq after read", 32'(irq), 32'h0);
    wr(`MSOC_IDX_BW_RATE, 8'h1F);
    wr(`MSOC_IDX_INT_EN, 8'h00);
    smp(13'sd0, 1);
    chk("irq masked", 32'(irq), 32'h0);
    rdc("low power ready", `MSOC_IDX_INT_SRC, 8'h80, 8'h80);
    wr(`MSOC_IDX_THR_FF, 8'h02);
    smp(13'sd0, 1);
    rdc("free fall", `MSOC_IDX_INT_SRC, 8'h04, 8'h04);
    smp(13'sd100, 1);
    rdc("no free fall", `MSOC_IDX_INT_SRC, 8'h04, 8'h00);
    $display("test interrupts done");

    rst();
    wr(`MSOC_IDX_THR_ACT, 8'h02);
    wr(`MSOC_IDX_THR_INACT, 8'h01);
    wr(`MSOC_IDX_TIME_INACT, 8'h03);
    wr(`MSOC_IDX_PWR, 8'h3C);
    smp(13'sd100, 1);
    rdc("no early act", `MSOC_IDX_INT_SRC, 8'h18, 8'h00);
    smp(13'sd0, 3);
    chk("asleep", 32'(asleep), 32'h1);
    rdc("status asleep", `MSOC_IDX_STATUS, 8'h08, 8'h08);
    rdc("inact event", `MSOC_IDX_INT_SRC, 8'h18, 8'h08);
    smp(13'sd0, 3);
    rdc("no inact again", `MSOC_IDX_INT_SRC, 8'h18, 8'h00);
    smp(13'sd100, 1);
    chk("awake", 32'(asleep), 32'h0);
    rdc("status awake", `MSOC_IDX_STATUS, 8'h78, 8'h70);
    rdc("act event", `MSOC_IDX_INT_SRC, 8'h18, 8'h10);
    smp(13'sd100, 1);
    rdc("no act again", `MSOC_IDX_INT_SRC, 8'h18, 8'h00);
    smp(13'sd0, 3);
    chk("asleep again", 32'(asleep), 32'h1);
    rdc("inact again", `MSOC_IDX_INT_SRC, 8'h18, 8'h08);
    smp(13'sd100, 1);
    smp(13'sd0, 3);
    chk("act pending blocks sleep", 32'(asleep), 32'h0);
    rdc("both pending", `MSOC_IDX_INT_SRC, 8'h18, 8'h18);
    $display("test link done");
    report_and_stop();
  end
endmodule

// file: verilog/msoc_ctrl.sv
// Motion detectors, link and autosleep sequencing, offset trim and data
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "msoc_map.svh"

module msoc_ctrl
  import msoc_pkg::*;
#(
  parameter int SMP_W = 13,
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Undecimated samples, 3.9 mg counts
  input wire logic smp_valid,
  input wire logic signed [SMP_W-1:0] smp_x,
  input wire logic signed [SMP_W-1:0] smp_y,
  input wire logic signed [SMP_W-1:0] smp_z,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Status
  output logic irq,
  output logic asleep
);

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction

  // Offset counts are worth four full-resolution counts
  function automatic logic signed [15:0] corr(
    input logic signed [15:0] r, input logic [7:0] o,
    input logic fr, input logic [1:0] rng);
    logic signed [15:0] s;
    logic signed [15:0] b;
    s = {{8{o[7]}}, o};
    b = fr ? r : (r >>> rng);
    if (fr || rng == 2'h0)
      s = s <<< 2;
    else if (rng == 2'h1)
      s = s <<< 1;
    else if (rng == 2'h3)
      s = s >>> 1;
    corr = 16'(b + s);
  endfunction

  logic [7:0] x_axis_offset_trim, y_axis_offset_trim, z_axis_offset_trim;
  logic [7:0] thr_act, thr_inact, time_inact, thr_ff;
  logic [7:0] bw_rate, pwr, int_en, int_src, fmt;
  logic [2:0] act_axes;
  logic [15:0] x_axis_sample, y_axis_sample, z_axis_sample;
  logic [15:0] dec_cnt;
  logic [7:0] quiet_cnt;
  msoc_link_t state;
  logic aw_got, w_got;
  logic [5:0] widx;
  logic [7:0] wbyte;
  logic wbyte_en;

  // ---------------------------------------------------------------
  // Detection on the undecimated stream
  // ---------------------------------------------------------------
  logic signed [15:0] rx, ry, rz;
  logic [15:0] ta, ti, tf;
  logic sv, act_hit, quiet, ff_hit, inact_hit;
  logic act_evt, inact_evt, ff_evt, tick;
  logic [2:0] over;
  logic [3:0] shift;
  logic [15:0] mask;
  logic signed [15:0] corr_x, corr_y, corr_z;
  logic [7:0] set_vec, next_src;
  logic rd_clr;

  assign rx = 16'(smp_x);
  assign ry = 16'(smp_y);
  assign rz = 16'(smp_z);
  assign ta = {4'h0, thr_act, 4'h0};
  assign ti = {4'h0, thr_inact, 4'h0};
  assign tf = {4'h0, thr_ff, 4'h0};
  assign sv = smp_valid && pwr[`MSOC_PWR_MEASURE];
  assign over = {mag(rx) > ta, mag(ry) > ta, mag(rz) > ta};
  assign act_hit = |over;
  assign quiet = mag(rx) <= ti && mag(ry) <= ti && mag(rz) <= ti;
  assign ff_hit = mag(rx) < tf && mag(ry) < tf && mag(rz) < tf;
  assign inact_hit = quiet && ({1'b0, quiet_cnt} + 9'h1 == {1'b0, time_inact});
  assign act_evt = sv && act_hit && state != msoc_seek_inact;
  assign inact_evt = sv && inact_hit && state != msoc_seek_act;
  assign ff_evt = sv && ff_hit;

  // Output rate comes from the same stream, decimated by a fixed 2^9 when asleep
  assign shift = asleep ? `MSOC_SLEEP_SHIFT
                        : `MSOC_RATE_MAX - bw_rate[3:0];
  assign mask = 16'((17'h1 << shift) - 17'h1);
  assign tick = sv && ((dec_cnt & mask) == mask);

  assign corr_x = corr(rx, x_axis_offset_trim, fmt[`MSOC_FMT_FULLRES],
                       fmt[1:0]);
  assign corr_y = corr(ry, y_axis_offset_trim, fmt[`MSOC_FMT_FULLRES],
                       fmt[1:0]);
  assign corr_z = corr(rz, z_axis_offset_trim, fmt[`MSOC_FMT_FULLRES],
                       fmt[1:0]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dec_cnt <= 16'h0000;
    else if (sv)
      dec_cnt <= dec_cnt + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      quiet_cnt <= 8'h00;
    else if (sv && !quiet)
      quiet_cnt <= 8'h00;
    else if (sv && quiet_cnt != 8'hFF)
      quiet_cnt <= quiet_cnt + 8'h01;
  end

  // Data registers; low power does not stop the data ready event
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      x_axis_sample <= 16'h0000;
      y_axis_sample <= 16'h0000;
      z_axis_sample <= 16'h0000;
    end
    else if (tick)
    begin
      x_axis_sample <= corr_x;
      y_axis_sample <= corr_y;
      z_axis_sample <= corr_z;
    end
  end

  // ---------------------------------------------------------------
  // Link and autosleep sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= msoc_free;
    else
      case (state)
        msoc_free:
          if (pwr[`MSOC_PWR_LINK])
            state <= msoc_seek_inact;
        msoc_seek_inact:
          if (!pwr[`MSOC_PWR_LINK])
            state <= msoc_free;
          else if (inact_evt)
            state <= msoc_seek_act;
        msoc_seek_act:
          if (!pwr[`MSOC_PWR_LINK])
            state <= msoc_free;
          else if (act_evt)
            state <= msoc_seek_inact;
        default:
          state <= msoc_free;
      endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      asleep <= 1'b0;
    else if (!(pwr[`MSOC_PWR_LINK] && pwr[`MSOC_PWR_AUTOSLP]
               && pwr[`MSOC_PWR_SLEEP]))
      asleep <= 1'b0;
    else if (act_evt)
      asleep <= 1'b0;
    else if (inact_evt && !int_src[`MSOC_INT_ACT])
      asleep <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      act_axes <= 3'h0;
    else if (act_evt)
      act_axes <= over;
  end

  // ---------------------------------------------------------------
  // Interrupt source, cleared by reading it
  // ---------------------------------------------------------------
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`MSOC_INT_DREADY] = tick;
    set_vec[`MSOC_INT_ACT] = act_evt;
    set_vec[`MSOC_INT_INACT] = inact_evt;
    set_vec[`MSOC_INT_FF] = ff_evt;
    next_src = (rd_clr ? 8'h00 : int_src) | set_vec;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_src <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      int_src <= next_src;
      irq <= |(next_src & int_en);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_fire, wr_ok;

  assign wr_fire = aw_got && w_got && !bvalid;
  assign widx = waddr[7:2];
  assign wbyte = wd[7:0];
  assign wbyte_en = wr_fire && ws[0];

  always_comb
  begin
    if (widx == `MSOC_IDX_OFS_X || widx == `MSOC_IDX_OFS_Y)
      wr_ok = 1'b1;
    else if (widx == `MSOC_IDX_OFS_Z || widx == `MSOC_IDX_THR_ACT)
      wr_ok = 1'b1;
    else if (widx == `MSOC_IDX_THR_INACT || widx == `MSOC_IDX_TIME_INACT)
      wr_ok = 1'b1;
    else if (widx == `MSOC_IDX_THR_FF || widx == `MSOC_IDX_BW_RATE)
      wr_ok = 1'b1;
    else if (widx == `MSOC_IDX_PWR || widx == `MSOC_IDX_INT_EN)
      wr_ok = 1'b1;
    else if (widx == `MSOC_IDX_FMT)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `MSOC_RESP_OKAY;
      waddr <= '0;
      wd <= 32'h00000000;
      ws <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        awready <= 1'b0;
        waddr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got <= 1'b1;
        wready <= 1'b0;
        wd <= wdata;
        ws <= wstrb;
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `MSOC_RESP_OKAY : `MSOC_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Offsets come up at zero on every power-on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      x_axis_offset_trim <= `MSOC_RST_ZERO;
      y_axis_offset_trim <= `MSOC_RST_ZERO;
      z_axis_offset_trim <= `MSOC_RST_ZERO;
      thr_act <= `MSOC_RST_ZERO;
      thr_inact <= `MSOC_RST_ZERO;
      time_inact <= `MSOC_RST_ZERO;
      thr_ff <= `MSOC_RST_ZERO;
      bw_rate <= `MSOC_RST_BW_RATE;
      pwr <= `MSOC_RST_ZERO;
      int_en <= `MSOC_RST_ZERO;
      fmt <= `MSOC_RST_ZERO;
    end
    else if (wbyte_en)
    begin
      if (widx == `MSOC_IDX_OFS_X)
        x_axis_offset_trim <= wbyte;
      else if (widx == `MSOC_IDX_OFS_Y)
        y_axis_offset_trim <= wbyte;
      else if (widx == `MSOC_IDX_OFS_Z)
        z_axis_offset_trim <= wbyte;
      else if (widx == `MSOC_IDX_THR_ACT)
        thr_act <= wbyte;
      else if (widx == `MSOC_IDX_THR_INACT)
        thr_inact <= wbyte;
      else if (widx == `MSOC_IDX_TIME_INACT)
        time_inact <= wbyte;
      else if (widx == `MSOC_IDX_THR_FF)
        thr_ff <= wbyte;
      else if (widx == `MSOC_IDX_BW_RATE)
        bw_rate <= {3'h0, wbyte[4:0]};
      else if (widx == `MSOC_IDX_PWR)
        pwr <= {2'h0, wbyte[5:2], 2'h0};
      else if (widx == `MSOC_IDX_INT_EN)
        int_en <= wbyte;
      else if (widx == `MSOC_IDX_FMT)
        fmt <= {4'h0, wbyte[3], 1'b0, wbyte[1:0]};
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [5:0] ridx;
  logic [7:0] rd_val;
  logic rd_ok, ar_fire;
  logic [7:0] motion_detect_status_reg;

  assign ridx = araddr[7:2];
  assign ar_fire = arvalid && arready;
  assign rd_clr = ar_fire && ridx == `MSOC_IDX_INT_SRC;
  assign motion_detect_status_reg = {1'b0, act_axes, asleep, 3'h0};

  always_comb
  begin
    rd_ok = 1'b1;
    if (ridx == `MSOC_IDX_OFS_X)
      rd_val = x_axis_offset_trim;
    else if (ridx == `MSOC_IDX_OFS_Y)
      rd_val = y_axis_offset_trim;
    else if (ridx == `MSOC_IDX_OFS_Z)
      rd_val = z_axis_offset_trim;
    else if (ridx == `MSOC_IDX_THR_ACT)
      rd_val = thr_act;
    else if (ridx == `MSOC_IDX_THR_INACT)
      rd_val = thr_inact;
    else if (ridx == `MSOC_IDX_TIME_INACT)
      rd_val = time_inact;
    else if (ridx == `MSOC_IDX_THR_FF)
      rd_val = thr_ff;
    else if (ridx == `MSOC_IDX_STATUS)
      rd_val = motion_detect_status_reg;
    else if (ridx == `MSOC_IDX_BW_RATE)
      rd_val = bw_rate;
    else if (ridx == `MSOC_IDX_PWR)
      rd_val = pwr;
    else if (ridx == `MSOC_IDX_INT_EN)
      rd_val = int_en;
    else if (ridx == `MSOC_IDX_INT_SRC)
      rd_val = int_src;
    else if (ridx == `MSOC_IDX_FMT)
      rd_val = fmt;
    else if (ridx == `MSOC_IDX_DATA_FIRST)
      rd_val = x_axis_sample[7:0];
    else if (ridx == `MSOC_IDX_DATA_FIRST + 6'h01)
      rd_val = x_axis_sample[15:8];
    else if (ridx == `MSOC_IDX_DATA_FIRST + 6'h02)
      rd_val = y_axis_sample[7:0];
    else if (ridx == `MSOC_IDX_DATA_FIRST + 6'h03)
      rd_val = y_axis_sample[15:8];
    else if (ridx == `MSOC_IDX_DATA_FIRST + 6'h04)
      rd_val = z_axis_sample[7:0];
    else if (ridx == `MSOC_IDX_DATA_LAST)
      rd_val = z_axis_sample[15:8];
    else
    begin
      rd_val = 8'h00;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `MSOC_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_val};
      rresp <= rd_ok ? `MSOC_RESP_OKAY : `MSOC_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_src_read_clear: assert property (
    rd_clr && set_vec == 8'h00 |=> int_src == 8'h00)
    else $error("int source not cleared by read");
  a_set_beats_clear: assert property (
    rd_clr && act_evt |=> int_src[`MSOC_INT_ACT])
    else $error("activity lost at read clear");
  a_sleep_blocked: assert property (
    int_src[`MSOC_INT_ACT] && !asleep |=> !asleep)
    else $error("autosleep with activity pending");
  a_link_to_act: assert property (
    state == msoc_seek_inact && inact_evt && pwr[`MSOC_PWR_LINK]
    |=> state == msoc_seek_act)
    else $error("inactivity did not arm activity");
  a_no_inact_seek: assert property (
    state == msoc_seek_act |-> !inact_evt)
    else $error("inactivity while seeking activity");
  a_link_to_inact: assert property (
    state == msoc_seek_act && act_evt && pwr[`MSOC_PWR_LINK]
    |=> state == msoc_seek_inact)
    else $error("activity did not arm inactivity");
  a_wake_on_act: assert property (
    asleep && act_evt |=> !asleep && int_src[`MSOC_INT_ACT])
    else $error("no wake on activity");
  a_data_offset: assert property (
    tick |=> x_axis_sample == $past(corr_x)
      && y_axis_sample == $past(corr_y)
      && z_axis_sample == $past(corr_z))
    else $error("data not offset corrected");
  a_undecim_act: assert property (
    sv && act_hit && state == msoc_free |=> int_src[`MSOC_INT_ACT])
    else $error("activity missed on raw stream");
  a_sleep_rate: assert property (
    asleep |-> shift == `MSOC_SLEEP_SHIFT)
    else $error("sleep rate not applied");

endmodule

// file: verilog/msoc_map.svh
// Register indices, field positions, reset values and rates of the block
`ifndef MSOC_MAP_SVH
`define MSOC_MAP_SVH

// Register indices; byte address is four times the index
`define MSOC_IDX_OFS_X 6'h1E
`define MSOC_IDX_OFS_Y 6'h1F
`define MSOC_IDX_OFS_Z 6'h20
`define MSOC_IDX_THR_ACT 6'h24
`define MSOC_IDX_THR_INACT 6'h25
`define MSOC_IDX_TIME_INACT 6'h26
`define MSOC_IDX_THR_FF 6'h28
`define MSOC_IDX_STATUS 6'h2B
`define MSOC_IDX_BW_RATE 6'h2C
`define MSOC_IDX_PWR 6'h2D
`define MSOC_IDX_INT_EN 6'h2E
`define MSOC_IDX_INT_SRC 6'h30
`define MSOC_IDX_FMT 6'h31
`define MSOC_IDX_DATA_FIRST 6'h32
`define MSOC_IDX_DATA_LAST 6'h37

// Interrupt source and enable bits
`define MSOC_INT_DREADY 7
`define MSOC_INT_ACT 4
`define MSOC_INT_INACT 3
`define MSOC_INT_FF 2

// Power control, rate, format and status bits
`define MSOC_PWR_LINK 5
`define MSOC_PWR_AUTOSLP 4
`define MSOC_PWR_MEASURE 3
`define MSOC_PWR_SLEEP 2
`define MSOC_BW_LOWPWR 4
`define MSOC_FMT_FULLRES 3
`define MSOC_STAT_ASLEEP 3

// Reset values
`define MSOC_RST_ZERO 8'h00
`define MSOC_RST_BW_RATE 8'h0A

// Fastest rate code and decimation used while asleep
`define MSOC_RATE_MAX 4'hF
`define MSOC_SLEEP_SHIFT 4'h9

// AXI responses
`define MSOC_RESP_OKAY 2'b00
`define MSOC_RESP_SLVERR 2'b10

`endif

// file: verilog/msoc_pkg.sv
// Types shared by the motion, sleep and offset controller
package msoc_pkg;

  typedef enum logic [1:0] {
    msoc_free = 2'b00,
    msoc_seek_inact = 2'b01,
    msoc_seek_act = 2'b10
  } msoc_link_t;

endpackage
